// [verilog/iqs_defs.svh]
/*
  Constants of the I/Q serial frame output block: register offsets, field
  positions, reset values and frame counts. Assumes it is included by bare
  name from every file that needs it.
*/
`ifndef IQS_DEFS_SVH
`define IQS_DEFS_SVH
// register offsets on the configuration port
`define IQS_ADDR_CTRL_A  6'h18
`define IQS_ADDR_CTRL_B  6'h19
`define IQS_ADDR_DIV     6'h1A
// reset values
`define IQS_RST_CTRL_A   8'h12
`define IQS_RST_CTRL_B   8'h07
`define IQS_RST_DIV      4'h1
// control A bit positions
`define IQS_A_ALT        7
`define IQS_A_EMBED      6
`define IQS_A_EFS        5
`define IQS_A_MTZ        4
`define IQS_A_MINV       3
`define IQS_A_LATE       2
`define IQS_A_CTZ        1
`define IQS_A_CINV       0
// control B fields
`define IQS_B_FOURWIRE   7
`define IQS_B_WIDTH      3
`define IQS_B_DRIVE_HI   2
// frame counts
`define IQS_BYTES_W16    4'h4
`define IQS_BYTES_W24    4'h6
`define IQS_LAST_BIT_EFS 4'h9
`define IQS_LAST_BIT     4'h7
`define IQS_TAIL_MORE    4'h9
`define IQS_RCNT_MAX     2'h3
`define IQS_SAMPLE_W     48
// status word lands right behind the I/Q payload
`define IQS_STAT_SHIFT_W24 48
`define IQS_STAT_SHIFT_W16 32
`endif

// [verilog/iqs_pkg.sv]
/*
  Types of the I/Q serial frame output block. Assumes nothing beyond a
  SystemVerilog compiler.
*/
package iqs_pkg;
  // bit sequencer states, gray along idle-marker-data-tail
  typedef enum logic [1:0] {
    IQS_IDLE = 2'b00,
    IQS_MARK = 2'b01,
    IQS_DATA = 2'b11,
    IQS_TAIL = 2'b10
  } iqs_state_t;
endpackage

// [verilog/iqs_buf2.sv]
/*
  Two-entry buffer with valid/ready on both sides. Assumes a single clock
  and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module iqs_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  logic [W-1:0] slot [2];
  logic [1:0]   count;
  logic         push;
  logic         pop;

  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;

  // occupancy; ready is a flop so the source sees an honest full
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count    <= 2'h0;
      in_ready <= 1'b1;
    end else begin
      count    <= count + 2'(push) - 2'(pop);
      in_ready <= (count + 2'(push) - 2'(pop)) != 2'h2;
    end
  end

  // slot 0 is always the head; a pop shifts slot 1 forward
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot[0] <= '0;
      slot[1] <= '0;
    end else begin
      if (pop) begin
        slot[0] <= (count == 2'h2) ? slot[1] : in_data;
      end else if (push && count == 2'h0) begin
        slot[0] <= in_data;
      end
      if (push && (count - 2'(pop)) == 2'h1) begin
        slot[1] <= in_data;
      end
    end
  end

  assign out_valid = count != 2'h0;
  assign out_data  = slot[0];
endmodule

// [verilog/iqs_frame_out.sv]
/*
  Serial I/Q frame output: control registers, bit clock divider, frame
  builder and bit sequencer. Assumes CLK runs at twice the modulator clock,
  samples arrive one per decimated output, and the configuration serial
  decoder delivers single-cycle register writes.
*/
`timescale 1ns/1ps
`include "iqs_defs.svh"
module iqs_frame_out
  import iqs_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // register access from the configuration port decoder
  input  wire logic        CFG_WRITE,
  input  wire logic [5:0]  CFG_ADDR,
  input  wire logic [7:0]  CFG_WDATA,
  output logic [7:0]       CFG_RDATA,
  // decimated samples and status sources
  input  wire logic        SAMPLE_VALID,
  input  wire logic [23:0] SAMPLE_I,
  input  wire logic [23:0] SAMPLE_Q,
  output logic             SAMPLE_READY,
  input  wire logic [7:0]  ATTENUATION,
  input  wire logic [5:0]  SIGNAL_STRENGTH_ESTIMATE,
  input  wire logic        MOD_RESET_EVENT,
  input  wire logic        GAIN_VOLTAGE_OPTION,
  // serial pins toward the host
  output logic             FRAME_MARKER_OUT,
  output logic             FRAME_MARKER_OE,
  output logic             SERIAL_BIT_CLOCK_OUT,
  output logic             SERIAL_BIT_CLOCK_OE,
  output logic             PRIMARY_SERIAL_OUT,
  output logic             SECONDARY_SERIAL_OUT,
  // static pin settings
  output logic [2:0]       OUTPUT_DRIVE_LEVEL,
  output logic             FOUR_WIRE_READBACK_EN
);
  // ==========================================================
  // control registers
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [3:0] div;

  // single write port; unmapped addresses are ignored
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_a <= `IQS_RST_CTRL_A;
      ctrl_b <= `IQS_RST_CTRL_B;
      div    <= `IQS_RST_DIV;
    end else if (CFG_WRITE) begin
      if (CFG_ADDR == `IQS_ADDR_CTRL_A) ctrl_a <= CFG_WDATA;
      if (CFG_ADDR == `IQS_ADDR_CTRL_B) ctrl_b <= CFG_WDATA;
      if (CFG_ADDR == `IQS_ADDR_DIV) div <= CFG_WDATA[3:0];
    end
  end

  // readback, unmapped reads zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CFG_RDATA <= 8'h00;
    end else begin
      unique case (CFG_ADDR)
        `IQS_ADDR_CTRL_A: CFG_RDATA <= ctrl_a;
        `IQS_ADDR_CTRL_B: CFG_RDATA <= ctrl_b;
        `IQS_ADDR_DIV:    CFG_RDATA <= {4'h0, div};
        default:          CFG_RDATA <= 8'h00;
      endcase
    end
  end

  logic alt;
  logic embed;
  logic embedded_framing;
  logic ww24;
  assign alt   = ctrl_a[`IQS_A_ALT];
  assign embed = ctrl_a[`IQS_A_EMBED];
  assign embedded_framing   = ctrl_a[`IQS_A_EFS];
  assign ww24  = ctrl_b[`IQS_B_WIDTH] && !GAIN_VOLTAGE_OPTION;

  // ==========================================================
  // bit clock divider: a bit lasts 2*div CLK cycles, high for the first half
  logic [4:0] cyc;
  logic [4:0] half;
  logic [4:0] last_cyc;
  logic       bit_edge;
  logic       clk_int;
  // a zero divisor would stall the port, so it behaves as one
  assign half     = (div == 4'h0) ? 5'h01 : {1'b0, div};
  assign last_cyc = 5'((half << 1) - 5'h01);
  assign bit_edge = cyc >= last_cyc;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cyc     <= 5'h00;
      clk_int <= 1'b1;
    end else begin
      cyc     <= bit_edge ? 5'h00 : 5'(cyc + 5'h01);
      clk_int <= bit_edge || ((cyc + 5'h01) < half);
    end
  end

  // ==========================================================
  // sample buffer
  logic        smp_valid;
  logic [47:0] smp_data;
  logic        load;

  iqs_buf2 #(
    .W (`IQS_SAMPLE_W)
  ) u_buf (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (SAMPLE_VALID),
    .in_data   ({SAMPLE_I, SAMPLE_Q}),
    .in_ready  (SAMPLE_READY),
    .out_valid (smp_valid),
    .out_data  (smp_data),
    .out_ready (load)
  );

  // ==========================================================
  // status bytes
  iqs_state_t  state;
  logic [1:0]  rcnt;
  logic        phase; // alternate mode: 0 sends attenuation, 1 sends reset/strength
  logic        report;
  logic [7:0]  gain_byte;
  logic [7:0]  stat_byte;
  logic [15:0] stat_word;
  logic [63:0] payload;
  logic [3:0]  nbytes;

  assign load      = bit_edge && state == IQS_IDLE && smp_valid;
  assign report    = load && embed && (!alt || phase);
  assign gain_byte = alt ? {ATTENUATION[7:1], 1'b0} : ATTENUATION;
  assign stat_byte = {rcnt, SIGNAL_STRENGTH_ESTIMATE[5:1],
                      alt ? 1'b1 : SIGNAL_STRENGTH_ESTIMATE[0]};
  assign stat_word = !alt ? {gain_byte, stat_byte}
                   : {(phase ? stat_byte : gain_byte), 8'h00};

  // I then Q left aligned, status packed right behind them
  always_comb begin
    payload = ww24 ? {smp_data, 16'h0000}
                   : {smp_data[47:32], smp_data[23:8], 32'h0};
    nbytes  = ww24 ? `IQS_BYTES_W24 : `IQS_BYTES_W16;
    if (embed) begin
      payload = payload | ({stat_word, 48'h0}
                >> (ww24 ? `IQS_STAT_SHIFT_W24 : `IQS_STAT_SHIFT_W16));
      nbytes  = 4'(nbytes + (alt ? 4'h1 : 4'h2));
    end
  end

  // reset event count; a new event in the report cycle is kept
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rcnt <= 2'h0;
    end else if (report) begin
      rcnt <= MOD_RESET_EVENT ? 2'h1 : 2'h0;
    end else if (MOD_RESET_EVENT && rcnt != `IQS_RCNT_MAX) begin
      rcnt <= 2'(rcnt + 2'h1);
    end
  end

  // alternation flips per frame that carries a status byte
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase <= 1'b0;
    end else if (load && embed && alt) begin
      phase <= !phase;
    end
  end

  // ==========================================================
  // bit sequencer; every change lands on a bit boundary
  logic [63:0] sh;
  logic [3:0]  nb;
  logic [3:0]  bpos;
  logic [3:0]  tail;
  logic        mark;
  logic        dout;
  logic [3:0]  last_bit;
  assign last_bit = embedded_framing ? `IQS_LAST_BIT_EFS : `IQS_LAST_BIT;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= IQS_IDLE;
      sh    <= 64'h0;
      nb    <= 4'h0;
      bpos  <= 4'h0;
      tail  <= 4'h0;
      mark  <= 1'b0;
      dout  <= 1'b1;
    end else if (bit_edge) begin
      mark <= 1'b0;
      unique case (state)
        IQS_IDLE: begin
          dout <= 1'b1;
          if (smp_valid) begin
            nb   <= nbytes;
            bpos <= 4'h0;
            if (!embedded_framing && !ctrl_a[`IQS_A_LATE]) begin
              // early marker owns the bit period before data
              state <= IQS_MARK;
              mark  <= 1'b1;
              sh    <= payload;
            end else begin
              state <= IQS_DATA;
              mark  <= !embedded_framing;
              dout  <= embedded_framing ? 1'b0 : payload[63];
              sh    <= embedded_framing ? payload : {payload[62:0], 1'b0};
            end
          end
        end
        IQS_MARK: begin
          state <= IQS_DATA;
          dout  <= sh[63];
          sh    <= {sh[62:0], 1'b0};
        end
        IQS_DATA: begin
          if (bpos == last_bit) begin
            bpos <= 4'h0;
            if (nb == 4'h1) begin
              dout  <= 1'b1;
              tail  <= `IQS_TAIL_MORE;
              state <= embedded_framing ? IQS_TAIL : IQS_IDLE;
            end else begin
              nb   <= 4'(nb - 4'h1);
              dout <= embedded_framing ? 1'b0 : sh[63];
              if (!embedded_framing) sh <= {sh[62:0], 1'b0};
            end
          end else begin
            bpos <= 4'(bpos + 4'h1);
            if (embedded_framing && bpos + 4'h1 == last_bit) begin
              dout <= 1'b1;
            end else begin
              dout <= sh[63];
              sh   <= {sh[62:0], 1'b0};
            end
          end
        end
        IQS_TAIL: begin
          dout <= 1'b1;
          tail <= 4'(tail - 4'h1);
          if (tail == 4'h1) state <= IQS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // pin stage: polarity and enables applied in one last flop for all pins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FRAME_MARKER_OUT      <= 1'b0;
      FRAME_MARKER_OE       <= 1'b0;
      SERIAL_BIT_CLOCK_OUT  <= 1'b1;
      SERIAL_BIT_CLOCK_OE   <= 1'b0;
      PRIMARY_SERIAL_OUT    <= 1'b1;
      SECONDARY_SERIAL_OUT  <= 1'b0;
      OUTPUT_DRIVE_LEVEL    <= 3'(`IQS_RST_CTRL_B);
      FOUR_WIRE_READBACK_EN <= 1'b0;
    end else begin
      // embedded framing parks the marker low
      FRAME_MARKER_OUT     <= !embedded_framing && (mark ^ ctrl_a[`IQS_A_MINV]);
      FRAME_MARKER_OE      <= !ctrl_a[`IQS_A_MTZ];
      SERIAL_BIT_CLOCK_OUT <= clk_int ^ ctrl_a[`IQS_A_CINV];
      SERIAL_BIT_CLOCK_OE  <= !ctrl_a[`IQS_A_CTZ];
      PRIMARY_SERIAL_OUT   <= dout;
      SECONDARY_SERIAL_OUT <= 1'b0;
      OUTPUT_DRIVE_LEVEL   <= ctrl_b[`IQS_B_DRIVE_HI:0];
      FOUR_WIRE_READBACK_EN <= ctrl_b[`IQS_B_FOURWIRE];
    end
  end

  // ==========================================================
  // checks
  a_marker_float: assert property (@(posedge CLK) disable iff (RST)
    $past(ctrl_a[`IQS_A_MTZ]) |-> !FRAME_MARKER_OE)
    else $error("marker driven while floated");
  a_efs_marker_low: assert property (@(posedge CLK) disable iff (RST)
    $past(embedded_framing) |-> !FRAME_MARKER_OUT)
    else $error("marker active with embedded framing");
  a_clock_rise_at_bit: assert property (@(posedge CLK) disable iff (RST)
    bit_edge |=> clk_int ##1 (clk_int == ($past(half) != 5'h01)))
    else $error("bit clock phase wrong");
  a_tail_high: assert property (@(posedge CLK) disable iff (RST)
    (state == IQS_TAIL) |-> dout)
    else $error("tail bit not high");
  a_idle_high: assert property (@(posedge CLK) disable iff (RST)
    (state == IQS_IDLE) |-> dout)
    else $error("idle bit not high");
  a_rcnt_saturate: assert property (@(posedge CLK) disable iff (RST)
    (rcnt == `IQS_RCNT_MAX && !report) |=> rcnt == `IQS_RCNT_MAX)
    else $error("reset count wrapped");
  a_alt_lsb_tag: assert property (@(posedge CLK) disable iff (RST)
    (alt && embed) |-> (stat_word[8] == phase && stat_word[7:0] == 8'h00))
    else $error("alternate byte tag wrong");
  a_frame_length: assert property (@(posedge CLK) disable iff (RST)
    (!embed && !ww24) |-> nbytes == `IQS_BYTES_W16)
    else $error("bare 16-bit frame not four bytes");
  a_early_marker: assert property (@(posedge CLK) disable iff (RST)
    (load && !embedded_framing && !ctrl_a[`IQS_A_LATE]) |=> mark && dout)
    else $error("early marker not one bit ahead");
  a_width_forced: assert property (@(posedge CLK) disable iff (RST)
    GAIN_VOLTAGE_OPTION |-> !ww24)
    else $error("24-bit width under gain-voltage option");

  // embedded framing: start bit of the first byte, stop bit of every byte, and the frame end
  a_efs_start_bit: assert property (@(posedge CLK) disable iff (RST)
    (load && embedded_framing) |=> !dout)
    else $error("start bit not low");
  a_efs_stop_bit: assert property (@(posedge CLK) disable iff (RST)
    (state == IQS_DATA && embedded_framing && bpos == last_bit) |-> dout)
    else $error("stop bit not high");
  a_tail_to_idle: assert property (@(posedge CLK) disable iff (RST)
    (bit_edge && state == IQS_TAIL && tail == 4'h1) |=> state == IQS_IDLE)
    else $error("tail did not end");

  // marker placement and width, clock float
  a_late_marker: assert property (@(posedge CLK) disable iff (RST)
    (load && !embedded_framing && ctrl_a[`IQS_A_LATE]) |=> (mark && state == IQS_DATA))
    else $error("late marker not on first data bit");
  a_marker_one_bit: assert property (@(posedge CLK) disable iff (RST)
    (mark && bit_edge) |=> !mark)
    else $error("marker longer than one bit");
  a_clock_float: assert property (@(posedge CLK) disable iff (RST)
    $past(ctrl_a[`IQS_A_CTZ]) |-> !SERIAL_BIT_CLOCK_OE)
    else $error("bit clock driven while floated");

  // status byte bookkeeping; the report clear is checked only in cycles without a new reset event
  a_rcnt_count: assert property (@(posedge CLK) disable iff (RST)
    (MOD_RESET_EVENT && !report && rcnt != `IQS_RCNT_MAX) |=> rcnt == 2'($past(rcnt) + 2'h1))
    else $error("reset event not counted");
  a_rcnt_cleared: assert property (@(posedge CLK) disable iff (RST)
    (report && !MOD_RESET_EVENT) |=> rcnt == 2'h0)
    else $error("reset count not cleared by report");
  a_alt_phase_flip: assert property (@(posedge CLK) disable iff (RST)
    (load && embed && alt) |=> phase != $past(phase))
    else $error("alternate byte did not switch");
  a_status_word_pack: assert property (@(posedge CLK) disable iff (RST)
    (embed && !alt) |-> stat_word == {ATTENUATION, rcnt, SIGNAL_STRENGTH_ESTIMATE})
    else $error("status word packed wrong");
endmodule

// [sim/iqs_host_rx.sv]
/*
  Host serial receive port model: takes data and marker at the falling bit
  clock edge, mid-bit. Assumes a non-inverted bit clock.
*/
`timescale 1ns/1ps
module iqs_host_rx (
  // clock
  input  wire logic clk,
  // serial pins from the device
  input  wire logic sck,
  input  wire logic sck_oe,
  input  wire logic mark,
  input  wire logic dat
);
  // ==========================================
  // capture
  logic prev_sck = 1'b1;
  int   cnt      = 0;
  int   period   = 0;
  logic bits[$];
  logic marks[$];
  // sampling mid-bit keeps clear of the launching edge; period is kept for the rate check
  always @(posedge clk) begin
    prev_sck <= sck;
    cnt <= cnt + 1;
    if (sck_oe && prev_sck && !sck) begin
      bits.push_back(dat);
      marks.push_back(mark);
      period <= cnt + 1;
      cnt <= 0;
    end
  end
endmodule

// [sim/iqs_frame_out_tb_top.sv]
/*
  Self-checking bench of the I/Q serial frame output. Assumes the design
  files and the host receiver model are compiled before it.
*/
`timescale 1ns/1ps
`include "iqs_defs.svh"
module iqs_frame_out_tb_top;
  // ==========================================
  // signals
  logic        clk, rst, cfg_write, sample_valid, mod_ev, gvo, full;
  logic [5:0]  cfg_addr, strength;
  logic [7:0]  cfg_wdata, cfg_rdata, atten;
  logic [23:0] sample_i, sample_q;
  logic        sample_ready, fm, fm_oe, sck, sck_oe, dout, dout_b, four_wire;
  logic [2:0]  drive;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          cycles    = 0;

  iqs_frame_out uut (.CLK(clk), .RST(rst), .CFG_WRITE(cfg_write), .CFG_ADDR(cfg_addr),
    .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .SAMPLE_VALID(sample_valid),
    .SAMPLE_I(sample_i), .SAMPLE_Q(sample_q), .SAMPLE_READY(sample_ready),
    .ATTENUATION(atten), .SIGNAL_STRENGTH_ESTIMATE(strength), .MOD_RESET_EVENT(mod_ev),
    .GAIN_VOLTAGE_OPTION(gvo), .FRAME_MARKER_OUT(fm), .FRAME_MARKER_OE(fm_oe),
    .SERIAL_BIT_CLOCK_OUT(sck), .SERIAL_BIT_CLOCK_OE(sck_oe), .PRIMARY_SERIAL_OUT(dout),
    .SECONDARY_SERIAL_OUT(dout_b), .OUTPUT_DRIVE_LEVEL(drive),
    .FOUR_WIRE_READBACK_EN(four_wire));
  iqs_host_rx host (.clk(clk), .sck(sck), .sck_oe(sck_oe), .mark(fm), .dat(dout));

  // ==========================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // the longest frame run stays far below this ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ==========================================
  // shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_write <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_write <= 1'b0;
  endtask
  task automatic reg_read(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    cfg_addr <= a;
    @(posedge clk);
    @(negedge clk);
    check(cfg_rdata, exp);
  endtask
  task automatic send(input logic [23:0] i, input logic [23:0] q);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_i     <= i;
    sample_q     <= q;
    @(negedge clk);
    while (!sample_ready) begin
      full = 1'b1;
      @(negedge clk);
    end
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask
  task automatic wait_bits(input int n);
    for (int k = 0; k < 20000 && host.bits.size() < n; k++) @(posedge clk);
  endtask
  task automatic clear_host();
    host.bits.delete();
    host.marks.delete();
  endtask
  // sends one sample and compares the whole frame bit by bit
  task automatic run_frame(input logic [23:0] i, input logic [23:0] q, input int w,
                           input logic [15:0] st, input int sb);
    int m;
    int c;
    logic [63:0] got;
    logic [63:0] exp;
    got = '0;
    exp = '0;
    c = 0;
    m = 0;
    clear_host();
    send(i, q);
    wait_bits(2 * w + sb + 30);
    while (m < 40 && host.marks[m] !== 1'b1) m++;
    for (int k = 0; k < 2 * w + sb; k++) got = {got[62:0], host.bits[m + 1 + k]};
    for (int k = 0; k < w; k++) exp = {exp[62:0], i[23 - k]};
    for (int k = 0; k < w; k++) exp = {exp[62:0], q[23 - k]};
    for (int k = 0; k < sb; k++) exp = {exp[62:0], st[15 - k]};
    foreach (host.marks[k]) c += (host.marks[k] === 1'b1);
    check(got, exp);
    check(host.bits[m + 1 + 2 * w + sb], 1'b1);
    check(c, 1);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    check({fm_oe, sck_oe, drive, four_wire, dout_b}, 7'b0011100);
    reg_read(`IQS_ADDR_CTRL_A, 8'h12);
    reg_read(`IQS_ADDR_CTRL_B, 8'h07);
    reg_read(`IQS_ADDR_DIV, 8'h01);
    reg_write(6'h05, 8'hFF);
    reg_read(6'h05, 8'h00);
  endtask
  task automatic t_basic();
    reg_write(`IQS_ADDR_CTRL_B, 8'h80);
    reg_write(`IQS_ADDR_CTRL_A, 8'h00);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({four_wire, drive, fm_oe, sck_oe}, 6'b100011);
    run_frame(24'h8001FF, 24'h7FFE00, 16, 16'h0, 0);
  endtask
  task automatic t_status();
    int ev[2] = '{2, 5};
    reg_write(`IQS_ADDR_CTRL_B, 8'h0F);
    reg_write(`IQS_ADDR_CTRL_A, 8'h40);
    atten    <= 8'hA5;
    strength <= 6'h3C;
    foreach (ev[j]) begin
      repeat (ev[j]) begin
        @(posedge clk) mod_ev <= 1'b1;
        @(posedge clk) mod_ev <= 1'b0;
      end
      run_frame(24'h123456, 24'hFEDCBA, 24, {8'hA5, (ev[j] > 3) ? 2'h3 : 2'h2, 6'h3C}, 16);
    end
  endtask
  task automatic t_alt();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reg_write(`IQS_ADDR_CTRL_B, 8'h00);
    reg_write(`IQS_ADDR_CTRL_A, 8'hC0);
    atten    <= 8'h5B;
    strength <= 6'h2A;
    run_frame(24'hABCD00, 24'h0, 16, 16'h5A00, 8);
    run_frame(24'hABCD00, 24'h0, 16, 16'h2B00, 8);
  endtask
  task automatic t_efs();
    int m;
    logic [63:0] got;
    got = '0;
    m = 0;
    reg_write(`IQS_ADDR_CTRL_A, 8'h24);  // late marker set, it must change nothing
    clear_host();
    send(24'h3C5A00, 24'h81FF00);
    wait_bits(80);
    while (m < 30 && host.bits[m] !== 1'b0) m++;
    for (int k = 0; k < 40; k++) got = {got[62:0], host.bits[m + k]};
    check(got, {1'b0, 8'h3C, 2'b10, 8'h5A, 2'b10, 8'h81, 2'b10, 8'hFF, 1'b1});
    for (int k = 40; k < 50; k++) got = {got[62:0], host.bits[m + k]};
    check(got[9:0], 10'h3FF);
    check({fm, fm_oe}, 2'b01);
  endtask
  task automatic t_div();
    reg_write(`IQS_ADDR_CTRL_A, 8'h00);
    reg_write(`IQS_ADDR_DIV, 8'hF3);
    reg_read(`IQS_ADDR_DIV, 8'h03);
    run_frame(24'h00FF00, 24'hFF0000, 16, 16'h0, 0);
    check(host.period, 6);
  endtask
  task automatic t_gain();
    reg_write(`IQS_ADDR_CTRL_B, 8'h08);
    gvo <= 1'b1;
    run_frame(24'hC3A500, 24'h5AC300, 16, 16'h0, 0);
  endtask
  // four samples back to back: the fourth must wait while two are held
  task automatic t_burst();
    logic [63:0] got;
    got = '0;
    full = 1'b0;
    clear_host();
    for (int s = 1; s <= 4; s++) send({s[7:0], 16'h0000}, 24'h0);
    wait_bits(4 * 33 + 10);
    for (int k = 0; k + 8 < host.marks.size(); k++) begin
      if (host.marks[k] === 1'b1) begin
        for (int b = 1; b <= 8; b++) got = {got[62:0], host.bits[k + b]};
      end
    end
    check(got, 64'h01020304);
    check(full, 1'b1);
  endtask
  // late marker rides on the first data bit instead of the bit before it
  task automatic t_late();
    int m;
    m = 0;
    reg_write(`IQS_ADDR_CTRL_A, 8'h04);
    clear_host();
    send(24'h400000, 24'h0);
    wait_bits(50);
    while (m < 40 && host.marks[m] !== 1'b1) m++;
    check({host.bits[m], host.bits[m + 1]}, 2'b01);
  endtask
  // inverted marker idles high; an inverted bit clock falls with the marker's lead
  task automatic t_invert();
    reg_write(`IQS_ADDR_CTRL_A, 8'h09);
    repeat (8) @(posedge clk);
    @(negedge clk);
    check({fm, fm_oe, sck_oe}, 3'b111);
    send(24'h0, 24'h0);
    for (int k = 0; k < 100 && fm !== 1'b0; k++) @(negedge clk);
    check({fm, sck}, 2'b00);
  endtask

  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    cfg_write = 1'b0;
    cfg_addr = 6'h00;
    cfg_wdata = 8'h00;
    sample_valid = 1'b0;
    sample_i = 24'h0;
    sample_q = 24'h0;
    atten = 8'h00;
    strength = 6'h00;
    mod_ev = 1'b0;
    gvo = 1'b0;
    full = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_basic();
    t_status();
    t_alt();
    t_efs();
    t_div();
    t_gain();
    t_burst();
    t_late();
    t_invert();
    complete_run();
  end
endmodule
